// ==== shared/dscp_map.svh ====
// Command codes, response words, field positions and register offsets
`ifndef DSCP_MAP_SVH
`define DSCP_MAP_SVH
`define DSCP_PKT_LAST 5'h10
`define DSCP_PKT_FIRST 5'h00
`define DSCP_CMD_NOP 16'h0000
`define DSCP_CMD_GO 16'h0c00
`define DSCP_CMD_RCPU 12'h218
`define DSCP_CMD_WCPU 12'h208
`define DSCP_MEM_MASK 16'hff3f
`define DSCP_CMD_MRD 16'h1900
`define DSCP_CMD_MWR 16'h1800
`define DSCP_CMD_DUMP 16'h1d00
`define DSCP_CMD_FILL 16'h1c00
`define DSCP_CMD_RCTL 16'h2980
`define DSCP_CMD_WCTL 16'h2880
`define DSCP_CMD_RDM 8'h2d
`define DSCP_CMD_WDM 8'h2c
`define DSCP_DM_PAT 3'h2
`define DSCP_SZ_BYTE 2'h0
`define DSCP_SZ_WORD 2'h1
`define DSCP_SZ_LONG 2'h2
`define DSCP_SZ_RSVD 2'h3
`define DSCP_STEP_BYTE 32'h00000001
`define DSCP_STEP_WORD 32'h00000002
`define DSCP_STEP_LONG 32'h00000004
`define DSCP_RSP_OK 17'h0ffff
`define DSCP_RSP_NOT_READY 17'h10000
`define DSCP_RSP_BUS_ERR 17'h10001
`define DSCP_RSP_ILLEGAL 17'h1ffff
`define DSCP_OFS_CTRL 8'h00
`define DSCP_OFS_STATUS 8'h04
`define DSCP_CTRL_RST 32'h00000001
`define DSCP_AXI_OKAY 2'h0
`define DSCP_AXI_SLVERR 2'h2
`endif

// ==== shared/dscp_pkg.sv ====
// Types shared by the debug serial command port
package dscp_pkg;
  typedef enum logic [3:0] {
    DSCP_ST_CMD = 4'b0001,
    DSCP_ST_EXT = 4'b0010,
    DSCP_ST_BUSY = 4'b0100,
    DSCP_ST_RES = 4'b1000
  } dscp_state_t;
  typedef enum logic [3:0] {
    DSCP_OP_NONE = 4'h0,
    DSCP_OP_CPU_RD = 4'h1,
    DSCP_OP_CPU_WR = 4'h2,
    DSCP_OP_MEM_RD = 4'h3,
    DSCP_OP_MEM_WR = 4'h4,
    DSCP_OP_CTL_RD = 4'h5,
    DSCP_OP_CTL_WR = 4'h6,
    DSCP_OP_GO = 4'h7,
    DSCP_OP_DM_RD = 4'h8,
    DSCP_OP_DM_WR = 4'h9
  } dscp_op_t;
  typedef struct packed {
    logic valid;
    dscp_op_t op;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dscp_req_t;
  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } dscp_rsp_t;
endpackage

// ==== rtl/dscp_sync.sv ====
// Two-flop synchroniser for link pins
module dscp_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // dscp_sync

// ==== rtl/dscp_port.sv ====
// Debug serial command port: link engine, command decoder, AXI4-Lite registers
// Functional notes
// - Three-line link, host drives serial clock
// - Full-duplex 17-bit packets, MSB first
// - Sample link, shift only on high clock
// - Status clear: result data or all ones
// - Status set: zero not ready, ones illegal
// - Bus error answers status set, data one
// - Operation word plus optional extension words
// - Read or write CPU address/data register
// - Memory read byte, word or longword
// - Memory write byte, word or longword
// - Dump continues after a memory read
// - Fill continues after a memory write
// - Resume execution, halted only
// - No-operation command, runs in parallel
// - Read or write system control register
// - Read or write debug-module register
// - Halted-only commands need halted CPU
// - Size codes byte, word, long; reserved
// - Two address words, long data two, MSW first
// - Not ready while memory access runs
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`include "dscp_map.svh"
module dscp_port
  import dscp_pkg::*;
#(
  parameter int DM_REGS = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic debug_serial_clock,
  input wire logic debug_serial_input,
  output logic debug_serial_output,
  input wire logic cpu_halted,
  output dscp_req_t core_req,
  input wire dscp_rsp_t core_rsp,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [1:0] link_s;
  logic sclk_s;
  logic sdi_s;
  logic armed_r;
  logic [4:0] bit_cnt_r;
  logic [15:0] rx_sr_r;
  logic [15:0] tx_sr_r;
  logic bit_en;
  logic pkt_done;
  logic [15:0] rx_word;
  logic [16:0] resp;
  logic [31:0] ctrl_r;
  logic port_en;
  dscp_state_t state_r;
  dscp_op_t op_r;
  logic [1:0] size_r;
  logic [31:0] addr_r;
  logic [31:0] data_r;
  logic [31:0] res_r;
  logic [15:0] cmd_r;
  logic [2:0] ext_left_r;
  logic [1:0] addr_left_r;
  logic [1:0] res_n_r;
  logic [1:0] res_cnt_r;
  logic res_rd_r;
  logic err_r;
  logic illegal_r;
  logic rd_chain_r;
  logic wr_chain_r;
  logic launch_r;
  logic internal_op;
  logic done;
  logic [31:0] dm_r [DM_REGS];
  logic [31:0] mem_addr;
  logic [31:0] mem_step;
  logic cmd_slot;
  logic open_res_r;

  // Decode results
  dscp_op_t d_op;
  logic [1:0] d_size;
  logic [1:0] d_addr_n;
  logic [2:0] d_ext;
  logic [1:0] d_res_n;
  logic d_legal;
  logic d_halt;
  logic d_keep_addr;

  // Register bus
  logic aw_full_r;
  logic w_full_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic axi_we;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Serial link engine
  dscp_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(aclk),
    .rst_n(aresetn),
    .d({debug_serial_clock, debug_serial_input}),
    .q(link_s)
  );
  assign sclk_s = link_s[1];
  assign sdi_s = link_s[0];
  assign port_en = ctrl_r[0];
  assign bit_en = port_en && sclk_s && armed_r;
  assign pkt_done = bit_en && (bit_cnt_r == `DSCP_PKT_LAST);
  // Top control bit is dropped; host keeps it zero
  assign rx_word = {rx_sr_r[14:0], sdi_s};

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !port_en)
    begin
      armed_r <= 1'b0;
    end
    else if (!sclk_s)
    begin
      armed_r <= 1'b1;
    end
    else if (bit_en)
    begin
      armed_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !port_en)
    begin
      bit_cnt_r <= `DSCP_PKT_FIRST;
      rx_sr_r <= '0;
    end
    else if (bit_en)
    begin
      rx_sr_r <= rx_word;
      bit_cnt_r <= pkt_done ? `DSCP_PKT_FIRST : bit_cnt_r + 5'h01;
    end
  end

  // Response chosen at the first bit, so it reflects state when the packet opens
  always_comb
  begin
    resp = `DSCP_RSP_OK;
    if (illegal_r)
    begin
      resp = `DSCP_RSP_ILLEGAL;
    end
    else if (state_r == DSCP_ST_EXT || state_r == DSCP_ST_BUSY)
    begin
      resp = `DSCP_RSP_NOT_READY;
    end
    else if (state_r == DSCP_ST_RES)
    begin
      if (err_r)
      begin
        resp = `DSCP_RSP_BUS_ERR;
      end
      else if (res_rd_r)
      begin
        resp = {1'b0, (res_cnt_r == 2'h2) ? res_r[31:16] : res_r[15:0]};
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      debug_serial_output <= 1'b0;
      tx_sr_r <= '0;
    end
    else if (bit_en)
    begin
      if (bit_cnt_r == `DSCP_PKT_FIRST)
      begin
        debug_serial_output <= resp[16];
        tx_sr_r <= resp[15:0];
      end
      else
      begin
        debug_serial_output <= tx_sr_r[15];
        tx_sr_r <= {tx_sr_r[14:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode
  always_comb
  begin
    d_op = DSCP_OP_NONE;
    d_size = rx_word[7:6];
    d_addr_n = 2'h0;
    d_ext = 3'h0;
    d_res_n = 2'h1;
    d_legal = 1'b1;
    d_halt = 1'b0;
    d_keep_addr = 1'b0;
    if (rx_word == `DSCP_CMD_NOP)
    begin
      d_op = DSCP_OP_NONE;
    end
    else if (rx_word == `DSCP_CMD_GO)
    begin
      d_op = DSCP_OP_GO;
      d_halt = 1'b1;
    end
    else if (rx_word[15:4] == `DSCP_CMD_RCPU || rx_word[15:4] == `DSCP_CMD_WCPU)
    begin
      d_op = rx_word[8] ? DSCP_OP_CPU_RD : DSCP_OP_CPU_WR;
      d_size = `DSCP_SZ_LONG;
      d_halt = 1'b1;
    end
    else if (rx_word == `DSCP_CMD_RCTL || rx_word == `DSCP_CMD_WCTL)
    begin
      d_op = rx_word[8] ? DSCP_OP_CTL_RD : DSCP_OP_CTL_WR;
      d_size = `DSCP_SZ_LONG;
      d_addr_n = 2'h2;
      d_halt = 1'b1;
    end
    else if ((rx_word[15:8] == `DSCP_CMD_RDM || rx_word[15:8] == `DSCP_CMD_WDM)
             && rx_word[7:5] == `DSCP_DM_PAT)
    begin
      d_op = rx_word[8] ? DSCP_OP_DM_RD : DSCP_OP_DM_WR;
      d_size = `DSCP_SZ_LONG;
    end
    else if ((rx_word & `DSCP_MEM_MASK) == `DSCP_CMD_MRD
             || (rx_word & `DSCP_MEM_MASK) == `DSCP_CMD_MWR)
    begin
      d_op = rx_word[8] ? DSCP_OP_MEM_RD : DSCP_OP_MEM_WR;
      d_addr_n = 2'h2;
    end
    else if ((rx_word & `DSCP_MEM_MASK) == `DSCP_CMD_DUMP)
    begin
      d_op = DSCP_OP_MEM_RD;
      d_keep_addr = 1'b1;
      d_legal = rd_chain_r;
    end
    else if ((rx_word & `DSCP_MEM_MASK) == `DSCP_CMD_FILL)
    begin
      d_op = DSCP_OP_MEM_WR;
      d_keep_addr = 1'b1;
      d_legal = wr_chain_r;
    end
    else
    begin
      d_legal = 1'b0;
    end
    if (d_size == `DSCP_SZ_RSVD || (d_halt && !cpu_halted))
    begin
      d_legal = 1'b0;
    end
    if (d_size == `DSCP_SZ_LONG && (rx_word[8] || d_op == DSCP_OP_CPU_RD))
    begin
      d_res_n = 2'h2;
    end
    d_ext = {1'b0, d_addr_n};
    if (!rx_word[8] && d_op != DSCP_OP_NONE && d_op != DSCP_OP_GO)
    begin
      d_ext = {1'b0, d_addr_n} + ((d_size == `DSCP_SZ_LONG) ? 3'h2 : 3'h1);
    end
  end

  // Alignment is forced, so no address error is ever reported
  always_comb
  begin
    mem_addr = addr_r;
    mem_step = `DSCP_STEP_BYTE;
    if (size_r == `DSCP_SZ_LONG)
    begin
      mem_addr = {addr_r[31:2], 2'h0};
      mem_step = `DSCP_STEP_LONG;
    end
    else if (size_r == `DSCP_SZ_WORD)
    begin
      mem_addr = {addr_r[31:1], 1'h0};
      mem_step = `DSCP_STEP_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  assign internal_op = (op_r == DSCP_OP_NONE) || (op_r == DSCP_OP_DM_RD)
                       || (op_r == DSCP_OP_DM_WR);
  assign done = (state_r == DSCP_ST_BUSY) && (internal_op ? launch_r : core_rsp.ack);
  assign cmd_slot = pkt_done && (state_r == DSCP_ST_CMD
                                 || (state_r == DSCP_ST_RES && open_res_r
                                     && res_cnt_r == 2'h1));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= DSCP_ST_CMD;
      op_r <= DSCP_OP_NONE;
      size_r <= `DSCP_SZ_BYTE;
      addr_r <= '0;
      data_r <= '0;
      res_r <= '0;
      cmd_r <= '0;
      ext_left_r <= 3'h0;
      addr_left_r <= 2'h0;
      res_n_r <= 2'h1;
      res_cnt_r <= 2'h1;
      res_rd_r <= 1'b0;
      err_r <= 1'b0;
      illegal_r <= 1'b0;
      rd_chain_r <= 1'b0;
      wr_chain_r <= 1'b0;
      launch_r <= 1'b0;
    end
    else
    begin
      launch_r <= 1'b0;
      if (bit_en && bit_cnt_r == `DSCP_PKT_FIRST)
      begin
        illegal_r <= 1'b0;
      end
      if (cmd_slot)
      begin
        cmd_r <= rx_word;
        if (!d_legal)
        begin
          illegal_r <= 1'b1;
          state_r <= DSCP_ST_CMD;
          rd_chain_r <= 1'b0;
          wr_chain_r <= 1'b0;
        end
        else
        begin
          op_r <= d_op;
          size_r <= d_size;
          res_n_r <= d_res_n;
          res_rd_r <= rx_word[8] || d_op == DSCP_OP_CPU_RD;
          data_r <= '0;
          ext_left_r <= d_ext;
          addr_left_r <= d_addr_n;
          rd_chain_r <= rd_chain_r && d_keep_addr;
          wr_chain_r <= wr_chain_r && d_keep_addr;
          if (!d_keep_addr)
          begin
            addr_r <= {27'h0, rx_word[4:0]};
          end
          if (d_ext == 3'h0)
          begin
            state_r <= DSCP_ST_BUSY;
            launch_r <= 1'b1;
          end
          else
          begin
            state_r <= DSCP_ST_EXT;
          end
        end
      end
      else if (pkt_done && state_r == DSCP_ST_EXT)
      begin
        if (addr_left_r != 2'h0)
        begin
          addr_r <= {addr_r[15:0], rx_word};
          addr_left_r <= addr_left_r - 2'h1;
        end
        else
        begin
          data_r <= {data_r[15:0], rx_word};
        end
        ext_left_r <= ext_left_r - 3'h1;
        if (ext_left_r == 3'h1)
        begin
          state_r <= DSCP_ST_BUSY;
          launch_r <= 1'b1;
        end
      end
      else if (pkt_done && state_r == DSCP_ST_RES && open_res_r)
      begin
        res_cnt_r <= res_cnt_r - 2'h1;
      end
      else if (done)
      begin
        state_r <= DSCP_ST_RES;
        err_r <= !internal_op && core_rsp.err;
        res_cnt_r <= (!internal_op && core_rsp.err) ? 2'h1 : res_n_r;
        res_r <= (op_r == DSCP_OP_DM_RD) ? dm_r[addr_r[4:0]] : core_rsp.rdata;
        if (op_r == DSCP_OP_MEM_RD || op_r == DSCP_OP_MEM_WR)
        begin
          addr_r <= mem_addr + mem_step;
          rd_chain_r <= op_r == DSCP_OP_MEM_RD && !core_rsp.err;
          wr_chain_r <= op_r == DSCP_OP_MEM_WR && !core_rsp.err;
        end
      end
    end
  end

  // A packet opened while busy answered not ready, so it may not consume a result
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      open_res_r <= 1'b0;
    end
    else if (bit_en && bit_cnt_r == `DSCP_PKT_FIRST)
    begin
      open_res_r <= (state_r == DSCP_ST_RES);
    end
  end

  // Request to the core; held until acknowledged
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_req <= '0;
    end
    else if (launch_r && !internal_op)
    begin
      core_req.valid <= 1'b1;
      core_req.op <= op_r;
      core_req.size <= size_r;
      core_req.addr <= (op_r == DSCP_OP_MEM_RD || op_r == DSCP_OP_MEM_WR) ? mem_addr : addr_r;
      core_req.wdata <= data_r;
    end
    else if (core_rsp.ack)
    begin
      core_req.valid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Debug-module registers; the serial write wins a same-cycle clash
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < DM_REGS; i++)
      begin
        dm_r[i] <= '0;
      end
    end
    else if (launch_r && op_r == DSCP_OP_DM_WR)
    begin
      dm_r[addr_r[4:0]] <= data_r;
    end
    else if (axi_we && awaddr_r[7])
    begin
      dm_r[awaddr_r[6:2]] <= merge(dm_r[awaddr_r[6:2]], wdata_r, wstrb_r);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r <= `DSCP_CTRL_RST;
    end
    else if (axi_we && awaddr_r == `DSCP_OFS_CTRL)
    begin
      ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  assign axi_we = aw_full_r && w_full_r && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DSCP_AXI_OKAY;
    end
    else
    begin
      if (s_axi_awready && s_axi_awvalid)
      begin
        awaddr_r <= s_axi_awaddr;
        aw_full_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wready && s_axi_wvalid)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_full_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (axi_we)
      begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r[7] || awaddr_r == `DSCP_OFS_CTRL) ? `DSCP_AXI_OKAY
                                                                    : `DSCP_AXI_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `DSCP_AXI_OKAY;
    end
    else if (s_axi_arready && s_axi_arvalid)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `DSCP_AXI_OKAY;
      if (s_axi_araddr[7])
      begin
        s_axi_rdata <= dm_r[s_axi_araddr[6:2]];
      end
      else if (s_axi_araddr == `DSCP_OFS_CTRL)
      begin
        s_axi_rdata <= ctrl_r;
      end
      else if (s_axi_araddr == `DSCP_OFS_STATUS)
      begin
        s_axi_rdata <= {cmd_r, 8'h00, core_req.valid, wr_chain_r, rd_chain_r, cpu_halted,
                        state_r};
      end
      else
      begin
        s_axi_rdata <= '0;
        s_axi_rresp <= `DSCP_AXI_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // dscp_port

// ==== testbench/dscp_properties.sv ====
// Concurrent checks on the debug serial command port pins
`include "dscp_map.svh"
module dscp_properties
  import dscp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic debug_serial_clock,
  input wire logic debug_serial_input,
  input wire logic debug_serial_output,
  input wire logic cpu_halted,
  input wire dscp_req_t core_req,
  input wire dscp_rsp_t core_rsp,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Sync chain lags two edges, so a low pin for three samples freezes the output
  AST_LINK_QUIET: assert property (
    !$past(debug_serial_clock, 2) && !$past(debug_serial_clock, 3)
    && !$past(debug_serial_clock, 4) |-> $stable(debug_serial_output))
    else $error("serial output moved while link clock low");
  AST_REQ_AFTER_BIT: assert property (
    $rose(core_req.valid) |-> $past(debug_serial_clock, 3) || $past(debug_serial_clock, 4)
    || $past(debug_serial_clock, 5))
    else $error("core request not tied to a serial bit");
  AST_CORE_HOLD: assert property (
    core_req.valid && !core_rsp.ack |=> core_req.valid && $stable(core_req))
    else $error("core request dropped or changed before ack");
  AST_HALTED_ONLY: assert property (
    core_req.valid && (core_req.op inside {DSCP_OP_CPU_RD, DSCP_OP_CPU_WR, DSCP_OP_CTL_RD,
    DSCP_OP_CTL_WR, DSCP_OP_GO}) |-> cpu_halted)
    else $error("halted-only request while core runs");
  AST_MEM_SIZE: assert property (
    core_req.valid && (core_req.op inside {DSCP_OP_MEM_RD, DSCP_OP_MEM_WR})
    |-> core_req.size != `DSCP_SZ_RSVD)
    else $error("memory request with reserved size");
  AST_LONG_ALIGN: assert property (
    core_req.valid && (core_req.op inside {DSCP_OP_MEM_RD, DSCP_OP_MEM_WR})
    && core_req.size == `DSCP_SZ_LONG |-> core_req.addr[1:0] == 2'h0)
    else $error("long memory request not aligned");
  AST_WR_RESP: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_WR_BUSY: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  AST_RD_RESP: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  AST_RD_DONE: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after handshake");
endmodule // dscp_properties

bind dscp_port dscp_properties chk (.*);

// ==== testbench/dscp_host.sv ====
// Behavioural development system driving the serial debug link
module dscp_host (
  output logic debug_serial_clock,
  output logic debug_serial_input,
  input wire logic debug_serial_output
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    debug_serial_clock = 1'b0;
    debug_serial_input = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One packet; 200 ns bit keeps well under a fifth of the core rate
  task automatic xfer(input logic [15:0] w, output logic [16:0] r);
    logic [16:0] tx;
    tx = {1'b0, w};
    #3;
    for (int i = 16; i >= 0; i--)
    begin
      debug_serial_input = tx[i];
      #20 debug_serial_clock = 1'b1;
      #95 r[i] = debug_serial_output;
      #5 debug_serial_clock = 1'b0;
      #80;
    end
    // Released line must not look like a held bit
    debug_serial_input = ~tx[0];
    // Pad to whole core cycles so no pin ever moves on a core clock edge
    #22;
  endtask
endmodule // dscp_host

// ==== testbench/dscp_port_test.sv ====
// Self-checking bench for the debug serial command port
`include "dscp_map.svh"
module dscp_port_test
  import dscp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0] n;
    logic [0:6][15:0] tx;
    logic [0:6][16:0] ex;
  } dscp_row_t;
  localparam logic [16:0] DN = `DSCP_RSP_OK;
  localparam logic [16:0] NR = `DSCP_RSP_NOT_READY;
  localparam logic [16:0] IL = `DSCP_RSP_ILLEGAL;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic debug_serial_clock, debug_serial_input, debug_serial_output;
  logic cpu_halted = 1'b1;
  dscp_req_t core_req;
  dscp_rsp_t core_rsp = '0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [16:0] r;
  logic [31:0] d;
  logic berr = 1'b0;
  int lat = 2;
  int cnt = 0;
  int error_cnt = 0;
  int n_compared = 0;
  // Packets: command first, then extension words; first answer belongs to the previous command
  dscp_row_t rows [16] = '{
    '{3'd2, {16'h0,16'h0,80'h0}, {17'h0,DN,85'h0}},
    '{3'd2, {16'h0c00,16'h0,80'h0}, {17'h0,DN,85'h0}},
    '{3'd5, {16'h1900,16'h0,16'h3001,16'h1d00,16'h0,32'h0}, {17'h0,NR,NR,17'h0c3d,17'h0c3e,34'h0}},
    '{3'd5, {16'h1940,16'h0,16'h1234,16'h1d40,16'h0,32'h0}, {17'h0,NR,NR,17'h2e08,17'h2e0a,34'h0}},
    '{3'd7, {16'h1980,16'h0,16'h2468,16'h0,16'h1d80,16'h0,16'h0},
      {17'h0,NR,NR,17'hdb97,17'h1854,17'hdb93,17'h1850}},
    '{3'd5, {16'h1800,16'h0,16'h2001,16'h00ab,16'h0,32'h0}, {17'h0,NR,NR,NR,DN,34'h0}},
    '{3'd7, {16'h1840,16'h0,16'h4000,16'h1111,16'h1c40,16'h2222,16'h0}, {17'h0,NR,NR,NR,DN,NR,DN}},
    '{3'd6, {16'h1880,16'h0,16'h5000,16'haaaa,16'hbbbb,32'h0}, {17'h0,NR,NR,NR,NR,DN,17'h0}},
    '{3'd3, {16'h2185,16'h0,16'h0,64'h0}, {17'h0,17'hfffa,17'h3c39,68'h0}},
    '{3'd4, {16'h2083,16'haaaa,16'h5555,16'h0,48'h0}, {17'h0,NR,NR,DN,51'h0}},
    '{3'd5, {16'h2980,16'h0,16'h0c05,16'h0,16'h0,32'h0}, {17'h0,NR,NR,17'hf3fa,17'h3039,34'h0}},
    '{3'd6, {16'h2880,16'h0,16'h0801,16'hdead,16'hbeef,32'h0}, {17'h0,NR,NR,NR,NR,DN,17'h0}},
    '{3'd2, {16'h1234,96'h0}, {17'h0,IL,85'h0}},
    '{3'd2, {16'h19c0,96'h0}, {17'h0,IL,85'h0}},
    '{3'd2, {16'h1c40,96'h0}, {17'h0,IL,85'h0}},
    '{3'd4, {16'h2c46,16'hcafe,16'hf00d,64'h0}, {17'h0,NR,NR,DN,51'h0}}};

  dscp_port dut (.*);
  dscp_host host (.*);

  always #12.5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////////
  // Core answers lat+1 cycles after the request; read data derived from the address
  always @(posedge aclk)
  begin
    core_rsp.ack <= 1'b0;
    if (core_req.valid && !core_rsp.ack)
    begin
      if (cnt == lat)
      begin
        core_rsp.ack <= 1'b1;
        core_rsp.err <= berr;
        core_rsp.rdata <= {~core_req.addr[15:0], core_req.addr[15:0] ^ 16'h3c3c};
        cnt <= 0;
      end
      else
        cnt <= cnt + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #2_000_000;
    error_cnt++;
    report_and_stop;
  end
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`DSCP_OFS_CTRL);
    chk(d, `DSCP_CTRL_RST);
    foreach (rows[i])
    begin
      host.xfer(16'h0, r);
      for (int p = 0; p < rows[i].n; p++)
      begin
        host.xfer(rows[i].tx[p], r);
        if (p > 0)
          chk(32'(r), 32'(rows[i].ex[p]));
      end
    end
    rd(8'h98);
    chk(d, 32'hcafef00d);
    wr(8'h94, 32'h12345678);
    host.xfer(16'h2d45, r);
    host.xfer(16'h0, r);
    chk(32'(r), 32'h1234);
    host.xfer(16'h0, r);
    chk(32'(r), 32'h5678);
    // Slow core with a bus error
    lat = 100;
    berr = 1'b1;
    host.xfer(16'h1940, r);
    host.xfer(16'h0, r);
    host.xfer(16'h6000, r);
    chk(32'(core_req.valid), 32'h1);
    chk(core_req.addr, 32'h6000);
    chk(32'(core_req.op), 32'(DSCP_OP_MEM_RD));
    chk(32'(core_req.size), 32'(`DSCP_SZ_WORD));
    host.xfer(16'h0, r);
    chk(32'(r), 32'(NR));
    host.xfer(16'h0, r);
    chk(32'(r), 32'(`DSCP_RSP_BUS_ERR));
    lat = 2;
    berr = 1'b0;
    // Running core refuses halted-only commands
    @(posedge aclk);
    cpu_halted <= 1'b0;
    host.xfer(16'h0c00, r);
    host.xfer(16'h0, r);
    chk(32'(r), 32'(IL));
    host.xfer(16'h2185, r);
    host.xfer(16'h0, r);
    chk(32'(r), 32'(IL));
    @(posedge aclk);
    cpu_halted <= 1'b1;
    @(posedge aclk);
    // Disabled port ignores a packet
    wr(`DSCP_OFS_CTRL, 32'h0);
    host.xfer(16'h1234, r);
    wr(`DSCP_OFS_CTRL, 32'h1);
    host.xfer(16'h0, r);
    chk(32'(r), 32'(DN));
    wr(8'h40, 32'h1);
    chk(32'(rs), 32'(`DSCP_AXI_SLVERR));
    wr(`DSCP_OFS_STATUS, 32'h1);
    chk(32'(rs), 32'(`DSCP_AXI_SLVERR));
    rd(8'h40);
    chk({d[29:0], rs}, 32'(`DSCP_AXI_SLVERR));
    report_and_stop;
  end
endmodule // dscp_port_test
